// >>> hdl/tape_record_formatter.sv
`timescale 1ns/100ps
module tape_record_formatter (
  input  wire logic                                clk_in,
  input  wire logic                                sys_rst_in,
  input  wire logic                                conv_done_in,
  input  wire logic                                frame_sync_in,
  input  wire logic [tape_fmt_pkg::WORD_BITS-1:0]  data_word_in,
  output logic      [tape_fmt_pkg::TRACKS-1:0]     head_pos_out,
  output logic      [tape_fmt_pkg::TRACKS-1:0]     head_neg_out,
  output logic                                     record_pulse_out,
  output logic                                     frame_latch_out
);

  // Track input vector from word, clock and frame latch
  function automatic logic [tape_fmt_pkg::TRACKS-1:0] track_map(
    input logic [tape_fmt_pkg::WORD_BITS-1:0] word,
    input logic                               latch
  );
    logic [tape_fmt_pkg::TRACKS-1:0] t;
    t = '0;
    t[tape_fmt_pkg::TRK_BIT9]  = word[8];
    t[tape_fmt_pkg::TRK_BIT1 +: 4] = word[3:0];
    t[tape_fmt_pkg::TRK_CLOCK] = 1'b1;
    t[tape_fmt_pkg::TRK_BIT5 +: 4] = word[7:4];
    t[tape_fmt_pkg::TRK_FRAME] = latch;
    return t;
  endfunction : track_map

  // Input synchronisers (stage 1 read only by stage 2)
  logic [tape_fmt_pkg::WORD_BITS-1:0] data_s1_r;
  logic [tape_fmt_pkg::WORD_BITS-1:0] data_s2_r;
  logic                               conv_s1_r;
  logic                               conv_s2_r;
  logic                               conv_s3_r;
  logic                               fs_s1_r;
  logic                               fs_s2_r;
  logic                               fs_s3_r;

  // Two-flop sync of the pins plus one delay stage for edge detection
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      data_s1_r <= '0;
      data_s2_r <= '0;
      conv_s1_r <= 1'b0;
      conv_s2_r <= 1'b0;
      conv_s3_r <= 1'b0;
      fs_s1_r   <= 1'b0;
      fs_s2_r   <= 1'b0;
      fs_s3_r   <= 1'b0;
    end else begin
      data_s1_r <= data_word_in;   // One means level below threshold
      data_s2_r <= data_s1_r;
      conv_s1_r <= conv_done_in;
      conv_s2_r <= conv_s1_r;
      conv_s3_r <= conv_s2_r;
      fs_s1_r   <= frame_sync_in;
      fs_s2_r   <= fs_s1_r;
      fs_s3_r   <= fs_s2_r;
    end
  end

  // Edge events
  logic conv_rise;
  logic fs_rise;
  logic lead;
  logic trail;

  logic                             pulse_r;
  logic                             pulse_nxt;
  logic [tape_fmt_pkg::CNT_W-1:0]   cnt_r;
  logic [tape_fmt_pkg::CNT_W-1:0]   cnt_nxt;
  logic                             latch_r;
  logic                             latch_nxt;
  logic [tape_fmt_pkg::TRACKS-1:0]  trk_in;
  logic [tape_fmt_pkg::TRACKS-1:0]  state_r;
  logic [tape_fmt_pkg::TRACKS-1:0]  state_nxt;
  logic [tape_fmt_pkg::TRACKS-1:0]  neg_r;

  // Conversion word settles ahead of its pulse, so the synced word is stable here
  assign conv_rise = conv_s2_r & ~conv_s3_r;
  assign fs_rise   = fs_s2_r & ~fs_s3_r;
  assign lead      = conv_rise & ~pulse_r;
  assign trail     = pulse_r & (cnt_r == '0);
  assign trk_in    = track_map(data_s2_r, latch_r);

  // Record pulse generator: one pulse per conversion edge, edges during a pulse ignored
  always_comb begin
    pulse_nxt = pulse_r;
    cnt_nxt   = cnt_r;
    if (lead) begin
      pulse_nxt = 1'b1;
      cnt_nxt   = tape_fmt_pkg::REC_CNT_LOAD;
    end else if (trail) begin
      pulse_nxt = 1'b0;
    end else if (pulse_r) begin
      cnt_nxt   = cnt_r - tape_fmt_pkg::CNT_W'(1);
    end
  end

  // Frame sync latch: set wins over the trailing-edge clear
  always_comb begin
    latch_nxt = latch_r;
    if (fs_rise) begin
      latch_nxt = 1'b1;
    end else if (trail) begin
      latch_nxt = 1'b0;
    end
  end

  // Per-track NRZ toggle: flip only on a one coinciding with the record pulse
  always_comb begin
    state_nxt = state_r;
    if (lead) begin
      state_nxt = state_r ^ trk_in;
    end
  end

  // State registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pulse_r <= 1'b0;
      cnt_r   <= '0;
      latch_r <= tape_fmt_pkg::LATCH_RST;
      state_r <= tape_fmt_pkg::TRACK_RST;
      neg_r   <= ~tape_fmt_pkg::TRACK_RST;
    end else begin
      pulse_r <= pulse_nxt;
      cnt_r   <= cnt_nxt;
      latch_r <= latch_nxt;
      state_r <= state_nxt;
      neg_r   <= ~state_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign head_pos_out     = state_r;
  assign head_neg_out     = neg_r;
  assign record_pulse_out = pulse_r;
  assign frame_latch_out  = latch_r;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_heads_opposite: assert property (state_r == ~neg_r)
    else $error("head outputs not complementary");

  chk_change_needs_pulse: assert property (state_r != $past(state_r) |-> $past(lead))
    else $error("track changed without record pulse");

  chk_track_update: assert property (lead |=> state_r == ($past(state_r) ^ $past(trk_in)))
    else $error("track update does not follow inputs");

  chk_clock_track: assert property (
    lead |=> state_r[tape_fmt_pkg::TRK_CLOCK] != $past(state_r[tape_fmt_pkg::TRK_CLOCK]))
    else $error("clock track did not toggle");

  chk_frame_written: assert property (
    lead && latch_r |=> state_r[tape_fmt_pkg::TRK_FRAME] != $past(state_r[tape_fmt_pkg::TRK_FRAME]))
    else $error("frame sync not recorded");

  chk_pulse_width: assert property ($rose(pulse_r) |-> ##99 pulse_r ##1 !pulse_r)
    else $error("record pulse length wrong");

  chk_latch_set: assert property (fs_rise |=> latch_r)
    else $error("frame latch not set");

  chk_latch_clear: assert property (trail && !fs_rise |=> !latch_r)
    else $error("frame latch not cleared at trailing edge");

  chk_latch_hold: assert property (!trail && !fs_rise |=> latch_r == $past(latch_r))
    else $error("frame latch changed without cause");

  // Record pulse timing
  chk_lead_loads_count: assert property (
    lead |=> pulse_r && cnt_r == tape_fmt_pkg::REC_CNT_LOAD)
    else $error("record pulse counter not loaded");

  chk_trail_ends_pulse: assert property (trail |=> !pulse_r)
    else $error("record pulse not ended at trailing edge");

  chk_pulse_no_restart: assert property (
    pulse_r && !trail |=> pulse_r && cnt_r == $past(cnt_r) - tape_fmt_pkg::CNT_W'(1))
    else $error("record pulse restarted or cut short");

  // Track contents at the record pulse, and head outputs complementary every cycle
  chk_frame_idle_hold: assert property (
    lead && !latch_r |=> state_r[tape_fmt_pkg::TRK_FRAME] == $past(state_r[tape_fmt_pkg::TRK_FRAME]))
    else $error("frame track changed with latch clear");

  chk_bit9_track: assert property (
    lead |=> state_r[tape_fmt_pkg::TRK_BIT9] == ($past(state_r[tape_fmt_pkg::TRK_BIT9]) ^ $past(data_s2_r[8])))
    else $error("bit 9 track does not follow word");

  chk_bit5_track: assert property (
    lead |=> state_r[tape_fmt_pkg::TRK_BIT5] == ($past(state_r[tape_fmt_pkg::TRK_BIT5]) ^ $past(data_s2_r[4])))
    else $error("bit 5 track does not follow word");

  chk_neg_outputs: assert property (head_neg_out == ~head_pos_out)
    else $error("head output pins not complementary");

  // Main scenarios
  cov_frame_record: cover property (lead && latch_r);
  cov_sync_in_pulse: cover property (pulse_r && fs_rise);
  cov_trailing: cover property (trail ##[1:300] lead);
  cov_drop_edge: cover property (pulse_r && conv_rise);
  cov_zero_word: cover property (lead && data_s2_r == '0);

endmodule : tape_record_formatter

// >>> hdl/tape_fmt_pkg.sv
package tape_fmt_pkg;
  // Word and track geometry
  localparam int WORD_BITS  = 9;
  localparam int TRACKS     = 11;
  // Zero-based track positions (track n sits at index n-1)
  localparam int TRK_BIT9   = 0;
  localparam int TRK_BIT1   = 1;
  localparam int TRK_BIT5   = 6;
  localparam int TRK_CLOCK  = 5;
  localparam int TRK_FRAME  = 10;
  // Timing: record pulse length, leading to trailing edge
  localparam int CLK_PERIOD_NS   = 10;
  localparam int REC_PULSE_NS    = 1000;
  localparam int REC_PULSE_CYC   = (REC_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   REC_PULSE_NS / CLK_PERIOD_NS;
  localparam int CNT_W           = 7;
  localparam logic [CNT_W-1:0] REC_CNT_LOAD = CNT_W'(REC_PULSE_CYC - 1);
  // Reset values
  localparam logic [TRACKS-1:0] TRACK_RST = 11'h000;
  localparam logic              LATCH_RST = 1'b0;
endpackage : tape_fmt_pkg

// >>> testbench/tape_src_model.sv
`timescale 1ns/100ps
// Converter and frame sync source on the far side of the formatter
module tape_src_model (
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic [8:0] word_in,
  input  wire logic       fs_in,
  output logic            conv_done_out,
  output logic      [8:0] data_out,
  output logic            frame_out
);
  initial begin
    conv_done_out = 1'b0;
    data_out      = 9'h000;
    frame_out     = 1'b0;
  end
  // Word and frame sync settle long before conversion complete rises
  always begin
    @(posedge clk_in);
    if (go_in) begin
      data_out  <= word_in;
      frame_out <= fs_in;
      repeat (50) @(posedge clk_in);
      conv_done_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      conv_done_out <= 1'b0;
      frame_out     <= 1'b0;
      data_out      <= ~word_in; // Released word no longer shows its value
    end
  end
endmodule : tape_src_model

// >>> testbench/parallel_nrz_tape_record_formatter_tb.sv
`timescale 1ns/100ps
module parallel_nrz_tape_record_formatter_tb;
  logic        clk_in     = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        go         = 1'b0;
  logic        fs         = 1'b0;
  logic [8:0]  word       = 9'h000;
  logic [8:0]  data_word;
  logic        conv_done, frame_sync, record_pulse, frame_latch;
  logic [10:0] head_pos, head_neg;
  logic [10:0] exp_pos    = 11'h000;
  int          mismatches = 0;
  int          checks     = 0;
  // Clock generator
  always #5 clk_in = ~clk_in;
  tape_src_model tape_src_model_i (.clk_in(clk_in), .go_in(go), .word_in(word),
    .fs_in(fs), .conv_done_out(conv_done), .data_out(data_word), .frame_out(frame_sync));
  tape_record_formatter tape_record_formatter_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .conv_done_in(conv_done), .frame_sync_in(frame_sync), .data_word_in(data_word),
    .head_pos_out(head_pos), .head_neg_out(head_neg), .record_pulse_out(record_pulse),
    .frame_latch_out(frame_latch));
  // Verdict and end of run
  task automatic end_sim;
    $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // Compares one result
  task automatic chk(string name, logic [10:0] exp, logic [10:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Bounded wait for the record pulse level, sampled on falling edges
  task automatic wait_pulse(logic lvl);
    int n;
    n = 0;
    @(negedge clk_in);
    while (record_pulse !== lvl && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 300) begin
      mismatches++;
      end_sim();
    end
  endtask : wait_pulse
  // One conversion; with drop set a second edge arrives inside the pulse
  task automatic scn_record(logic [8:0] w, logic f, logic drop);
    time t_rise;
    int  width;
    @(posedge clk_in);
    word <= w;
    fs   <= f;
    go   <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    exp_pos ^= {f, w[7:4], 1'b1, w[3:0], w[8]};
    wait_pulse(1'b1);
    t_rise = $time;
    chk("head_pos", exp_pos, head_pos);
    chk("head_neg", ~exp_pos, head_neg);
    chk("frame_latch", {10'h000, f}, {10'h000, frame_latch});
    // Second conversion lands while the record pulse still stands
    if (drop) begin
      @(posedge clk_in);
      go <= 1'b1;
      repeat (10) @(posedge clk_in);
      go <= 1'b0;
    end
    wait_pulse(1'b0);
    width = int'(($time - t_rise) / tape_fmt_pkg::CLK_PERIOD_NS);
    chk("pulse_width", 11'(tape_fmt_pkg::REC_PULSE_CYC), width[10:0]);
    chk("latch_clear", 11'h000, {10'h000, frame_latch});
    repeat (60) @(negedge clk_in);
    chk("no_retrigger", 11'h000, {10'h000, record_pulse});
    chk("head_hold", exp_pos, head_pos);
  endtask : scn_record
  // Reset in mid-run returns every track and the latch to zero
  task automatic scn_reset;
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk("mid_rst_pos", 11'h000, head_pos);
    chk("mid_rst_neg", 11'h7ff, head_neg);
    chk("mid_rst_latch", 11'h000, {10'h000, frame_latch});
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    exp_pos = 11'h000;
  endtask : scn_reset
  // Main sequence
  initial begin
    @(negedge clk_in);
    chk("rst_pos", 11'h000, head_pos);
    chk("rst_neg", 11'h7ff, head_neg);
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    scn_record(9'h000, 1'b0, 1'b0);
    for (int i = 0; i < 9; i++) scn_record(9'h001 << i, i == 4, 1'b0);
    scn_reset();
    scn_record(9'h1ff, 1'b1, 1'b1);
    end_sim();
  end
endmodule : parallel_nrz_tape_record_formatter_tb
